//--- hw/dacurc_top.sv
// Top: command decode, input and output registers, strobe and reset control
`timescale 1ns/1ns
module dacurc_top
    import dacurc_pkg::*;
(
    // System
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial link
    input wire logic i_link_clk,
    input wire logic i_frame_n,
    input wire logic i_link_data,
    // Pins
    input wire logic i_load_strobe_n,
    input wire logic i_hw_reset_n,
    input wire logic i_reset_level_select,
    // Converter side
    output logic [11:0] o_code_a,
    output logic [11:0] o_code_b,
    output logic o_ref_off,
    output logic [1:0] o_mask,
    output logic o_por_busy
);
    logic [23:0] frame;
    logic frame_done;

    dacurc_shift u_shift (
        .i_link_clk(i_link_clk),
        .i_frame_n(i_frame_n),
        .i_link_data(i_link_data),
        .o_frame(frame),
        .o_frame_done(frame_done)
    );

    typedef struct packed {
        logic [2:0] done_sync;
        logic [2:0] load_strobe_n_sync;
        logic [2:0] rst_sync;
        logic [2:0] sel_sync;
        logic load_strobe_n_q;
        logic rst_q;
        logic sel_q;
        logic [7:0] por_cnt;
        logic por;
        logic [11:0] in_a;
        logic [11:0] in_b;
        logic [11:0] out_a;
        logic [11:0] out_b;
        logic [1:0] mask;
        logic ref_off;
        logic [23:0] frame_q;
        logic done_q;
        logic frame_pend;
    } dacurc_st_s;

    dacurc_st_s st;
    dacurc_st_s next_st;

    logic frame_ev;
    logic load_strobe_n_fall;
    logic [3:0] cmd;
    logic sel_a;
    logic sel_b;
    logic [11:0] data;
    logic [11:0] clear_code;
    logic [1:0] load_strobe_n_en;

    always_comb begin
        next_st = st;
        frame_ev = 1'b0;
        load_strobe_n_fall = 1'b0;
        cmd = st.frame_q[DACURC_CMD_MSB:DACURC_CMD_LSB];
        sel_a = st.frame_q[DACURC_ADDR_A];
        sel_b = st.frame_q[DACURC_ADDR_B];
        data = st.frame_q[DACURC_DATA_MSB:DACURC_DATA_LSB];
        clear_code = st.sel_q ? DACURC_MID_CODE : DACURC_ZERO_CODE;
        load_strobe_n_en = 2'h0;
        // Synchronisers; change taken once second and third agree
        next_st.done_sync = {st.done_sync[1:0], frame_done};
        next_st.load_strobe_n_sync = {st.load_strobe_n_sync[1:0], i_load_strobe_n};
        next_st.rst_sync = {st.rst_sync[1:0], i_hw_reset_n};
        next_st.sel_sync = {st.sel_sync[1:0], i_reset_level_select};
        if (st.load_strobe_n_sync[2] == st.load_strobe_n_sync[1]) begin
            next_st.load_strobe_n_q = st.load_strobe_n_sync[2];
        end
        if (st.rst_sync[2] == st.rst_sync[1]) begin
            next_st.rst_q = st.rst_sync[2];
        end
        if (st.sel_sync[2] == st.sel_sync[1]) begin
            next_st.sel_q = st.sel_sync[2];
        end
        if (st.done_sync[2] == st.done_sync[1]) begin
            next_st.done_q = st.done_sync[2];
        end
        // Frame ready rise: capture the frame, act on it next cycle
        if (!st.done_q && next_st.done_q) begin
            frame_ev = 1'b1;
            next_st.frame_q = frame;
        end
        next_st.frame_pend = frame_ev;
        load_strobe_n_fall = st.load_strobe_n_q & ~next_st.load_strobe_n_q;
        if (st.por) begin
            // Power-on reset: strobe and reset pins ignored, input and output registers held at clear code
            next_st.in_a = clear_code;
            next_st.in_b = clear_code;
            next_st.out_a = clear_code;
            next_st.out_b = clear_code;
            next_st.load_strobe_n_q = 1'b1;
            next_st.rst_q = 1'b1;
            if (st.por_cnt == 8'h00) begin
                next_st.por = 1'b0;
            end else begin
                next_st.por_cnt = st.por_cnt - 8'h01;
            end
        end else if (!st.rst_q) begin
            // Hardware reset: clear and block updates
            next_st.out_a = clear_code;
            next_st.out_b = clear_code;
            next_st.in_a = clear_code;
            next_st.in_b = clear_code;
        end else begin
            // Strobe edge on unmasked channels; mask ignored when held low
            load_strobe_n_en[0] = load_strobe_n_fall & ~st.mask[0];
            load_strobe_n_en[1] = load_strobe_n_fall & ~st.mask[1];
            if (load_strobe_n_en[0]) begin
                next_st.out_a = st.in_a;
            end
            if (load_strobe_n_en[1]) begin
                next_st.out_b = st.in_b;
            end
            if (st.frame_pend) begin
                unique case (cmd)
                    DACURC_CMD_WR_IN: begin
                        if (sel_a) begin
                            next_st.in_a = data;
                            if (!st.load_strobe_n_q) begin
                                next_st.out_a = data;
                            end
                        end
                        if (sel_b) begin
                            next_st.in_b = data;
                            if (!st.load_strobe_n_q) begin
                                next_st.out_b = data;
                            end
                        end
                    end
                    DACURC_CMD_UPD: begin
                        if (sel_a) begin
                            next_st.out_a = st.in_a;
                        end
                        if (sel_b) begin
                            next_st.out_b = st.in_b;
                        end
                    end
                    DACURC_CMD_WR_UPD: begin
                        if (sel_a) begin
                            next_st.in_a = data;
                            next_st.out_a = data;
                        end
                        if (sel_b) begin
                            next_st.in_b = data;
                            next_st.out_b = data;
                        end
                    end
                    DACURC_CMD_MASK: begin
                        next_st.mask = {st.frame_q[DACURC_MASK_B_BIT],
                            st.frame_q[DACURC_MASK_A_BIT]};
                    end
                    DACURC_CMD_SWRST: begin
                        next_st.por = 1'b1;
                        next_st.por_cnt = DACURC_POR_CYC;
                        next_st.mask = DACURC_MASK_RST;
                        next_st.ref_off = DACURC_REF_OFF_RST;
                    end
                    DACURC_CMD_REF: begin
                        next_st.ref_off = st.frame_q[DACURC_REF_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
            st.done_sync <= 3'h0;
            st.load_strobe_n_sync <= DACURC_SYNC_RST;
            st.rst_sync <= DACURC_SYNC_RST;
            st.load_strobe_n_q <= 1'b1;
            st.rst_q <= 1'b1;
            st.por <= 1'b1;
            st.por_cnt <= DACURC_POR_CYC;
            st.in_a <= DACURC_ZERO_CODE;
            st.in_b <= DACURC_ZERO_CODE;
            st.out_a <= DACURC_ZERO_CODE;
            st.out_b <= DACURC_ZERO_CODE;
            st.mask <= DACURC_MASK_RST;
            st.ref_off <= DACURC_REF_OFF_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_code_a = st.out_a;
    assign o_code_b = st.out_b;
    assign o_ref_off = st.ref_off;
    assign o_mask = st.mask;
    assign o_por_busy = st.por;
endmodule

//--- hw/dacurc_pkg.sv
// Package: constants for the converter update and reset control
package dacurc_pkg;
    localparam int DACURC_W = 12;
    localparam int DACURC_FRAME_W = 24;
    localparam logic [3:0] DACURC_CMD_WR_IN = 4'h1;
    localparam logic [3:0] DACURC_CMD_UPD = 4'h2;
    localparam logic [3:0] DACURC_CMD_WR_UPD = 4'h3;
    localparam logic [3:0] DACURC_CMD_MASK = 4'h5;
    localparam logic [3:0] DACURC_CMD_SWRST = 4'h6;
    localparam logic [3:0] DACURC_CMD_REF = 4'h7;
    localparam int DACURC_CMD_MSB = 23;
    localparam int DACURC_CMD_LSB = 20;
    localparam int DACURC_ADDR_A = 16;
    localparam int DACURC_ADDR_B = 19;
    localparam int DACURC_DATA_MSB = 15;
    localparam int DACURC_DATA_LSB = 4;
    localparam int DACURC_MASK_B_BIT = 3;
    localparam int DACURC_MASK_A_BIT = 0;
    localparam int DACURC_REF_BIT = 0;
    localparam logic [11:0] DACURC_ZERO_CODE = 12'h000;
    localparam logic [11:0] DACURC_MID_CODE = 12'h800;
    localparam logic DACURC_REF_OFF_RST = 1'h0;
    localparam logic [1:0] DACURC_MASK_RST = 2'h0;
    // Power-on reset duration in link-independent clocks
    localparam int DACURC_POR_NS = 2000;
    localparam int DACURC_CLK_NS = 100;
    localparam logic [7:0] DACURC_POR_CYC =
        8'((DACURC_POR_NS + DACURC_CLK_NS - 1) / DACURC_CLK_NS);
    localparam logic [4:0] DACURC_BIT_CNT_RST = 5'h00;
    localparam logic [4:0] DACURC_BIT_LAST = 5'h17;
    localparam logic [2:0] DACURC_SYNC_RST = 3'h7;
endpackage

//--- hw/dacurc_shift.sv
// Shift register capturing 24-bit frames on the link clock
`timescale 1ns/1ns
module dacurc_shift
    import dacurc_pkg::*;
(
    // Link side
    input wire logic i_link_clk,
    input wire logic i_frame_n,
    input wire logic i_link_data,
    // Frame output, ready level held until a link clock edge with the frame input high
    output logic [23:0] o_frame,
    output logic o_frame_done
);
    typedef struct packed {
        logic [23:0] sh;
        logic [4:0] cnt;
        logic [23:0] frame;
        logic done;
    } dacurc_sh_s;

    dacurc_sh_s st;
    dacurc_sh_s next_st;

    always_comb begin
        next_st = st;
        if (i_frame_n) begin
            // Idle edge also settles the ready level; no link reset
            next_st.cnt = DACURC_BIT_CNT_RST;
            next_st.done = 1'b0;
        end else if (st.cnt <= DACURC_BIT_LAST) begin
            next_st.sh = {st.sh[22:0], i_link_data};
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt == DACURC_BIT_LAST) begin
                next_st.frame = {st.sh[22:0], i_link_data};
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_link_clk) begin
        st <= next_st;
    end

    assign o_frame = st.frame;
    assign o_frame_done = st.done;
endmodule

//--- verification/dacurc_props.sv
// Checker for the converter update and reset control
`timescale 1ns/1ns
module dacurc_props
    import dacurc_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_frame_n,
    input wire logic i_load_strobe_n,
    input wire logic i_hw_reset_n,
    input wire logic i_reset_level_select,
    input wire logic [11:0] o_code_a,
    input wire logic [11:0] o_code_b,
    input wire logic o_ref_off,
    input wire logic [1:0] o_mask,
    input wire logic o_por_busy
);
    logic [11:0] clr;
    assign clr = i_reset_level_select ? DACURC_MID_CODE : DACURC_ZERO_CODE;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_por_defaults: assert property (o_por_busy
        && $past(o_por_busy) |-> o_mask == 2'h0 && !o_ref_off)
        else $error("defaults lost in reset");
    a_por_length: assert property ($fell(i_rst) |->
        o_por_busy[*8] ##[11:15] !o_por_busy) else $error("reset length");
    a_por_clear_code: assert property ($fell(o_por_busy) |->
        o_code_a == clr && o_code_b == clr) else $error("power-up code");
    a_hw_reset_clear: assert property (!i_hw_reset_n[*6] |->
        o_code_a == clr && o_code_b == clr) else $error("clear code");
    a_hw_reset_block: assert property (!i_hw_reset_n[*6] |=>
        $stable(o_code_a) && $stable(o_code_b)) else $error("update in reset");
    a_strobe_masked: assert property ($fell(i_load_strobe_n)
        && o_mask[0] |=> $stable(o_code_a)[*6])
        else $error("masked channel updated");
    a_quiet_codes: assert property ((i_frame_n && i_load_strobe_n
        && i_hw_reset_n && !o_por_busy)[*8] |-> $stable(o_code_a)
        && $stable(o_code_b)) else $error("codes moved while idle");
    a_quiet_regs: assert property ((i_frame_n && !o_por_busy)[*8] |->
        $stable(o_mask) && $stable(o_ref_off)) else $error("mask moved");
    c_por_end: cover property ($fell(o_por_busy));
    c_strobe: cover property ($fell(i_load_strobe_n) && !o_mask[0]);
    c_ref_off: cover property ($rose(o_ref_off));
endmodule
bind dacurc_top dacurc_props u_props (.*);

//--- verification/dacurc_host.sv
// Serial bus host model sending 24-bit command frames
`timescale 1ns/1ns
module dacurc_host (
    // Link
    output logic o_link_clk,
    output logic o_frame_n,
    output logic o_link_data
);
    initial begin
        o_link_clk = 0;
        o_frame_n = 1;
        o_link_data = 0;
    end
    // Command in top nibble, MSB first
    task automatic send(input logic [23:0] f);
        int i;
        #11 o_link_clk = 1;
        #24 o_link_clk = 0;
        o_frame_n = 0;
        for (i = 23; i >= 0; i--) begin
            o_link_data = f[i];
            #24 o_link_clk = 1;
            #24 o_link_clk = 0;
        end
        #24 o_frame_n = 1;
        o_link_data = ~o_link_data;
    endtask
endmodule

//--- verification/dacurc_top_tb.sv
// Testbench for the converter update and reset control
`timescale 1ns/1ns
module dacurc_top_tb;
    import dacurc_pkg::*;
    logic clk = 0, rst = 1, strb_n = 1, hw_n = 1, sel = 1;
    logic link_clk, frame_n, link_data, ref_off, busy;
    logic [11:0] code_a, code_b;
    logic [1:0] mask;
    int n_fail = 0, check_count = 0;
    always #50 clk = ~clk;
    dacurc_host u_host (.o_link_clk(link_clk), .o_frame_n(frame_n),
        .o_link_data(link_data));
    dacurc_top DUT (.i_clk(clk), .i_rst(rst), .i_link_clk(link_clk),
        .i_frame_n(frame_n), .i_link_data(link_data),
        .i_load_strobe_n(strb_n), .i_hw_reset_n(hw_n),
        .i_reset_level_select(sel), .o_code_a(code_a), .o_code_b(code_b),
        .o_ref_off(ref_off), .o_mask(mask), .o_por_busy(busy));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic frm(input logic [3:0] c, a, input logic [15:0] d);
        u_host.send({c, a, d});
        clks(12);
    endtask
    task automatic wait_por();
        int i;
        for (i = 0; i < 40 && busy !== 1'b0; i++) clks(1);
        clks(2);
    endtask
    task automatic pulse();
        strb_n = 0;
        clks(2);
        strb_n = 1;
        clks(8);
    endtask
    task automatic t_por();
        wait_por();
        chk({11'h0, busy}, 12'h000);
        chk(code_a, DACURC_MID_CODE);
        chk(code_b, DACURC_MID_CODE);
        chk({11'h0, ref_off}, 12'h000);
        chk({10'h0, mask}, 12'h000);
        $display("test power-up done");
    endtask
    task automatic t_cmds();
        frm(DACURC_CMD_WR_IN, 4'h1, 16'h1230);
        chk(code_a, DACURC_MID_CODE);
        frm(DACURC_CMD_UPD, 4'h1, 16'hFFF0);
        chk(code_a, 12'h123);
        frm(DACURC_CMD_WR_UPD, 4'h8, 16'hABC0);
        chk(code_b, 12'hABC);
        chk(code_a, 12'h123);
        $display("test commands done");
    endtask
    task automatic t_mask();
        frm(DACURC_CMD_MASK, 4'h0, 16'h0001);
        chk({10'h0, mask}, 12'h001);
        frm(DACURC_CMD_WR_IN, 4'h9, 16'h4560);
        pulse();
        chk(code_a, 12'h123);
        chk(code_b, 12'h456);
        frm(DACURC_CMD_MASK, 4'h0, 16'h0008);
        chk({10'h0, mask}, 12'h002);
        pulse();
        chk(code_a, 12'h456);
        strb_n = 0;
        clks(6);
        frm(DACURC_CMD_WR_IN, 4'h8, 16'h7890);
        chk(code_b, 12'h789);
        strb_n = 1;
        clks(6);
        $display("test strobe done");
    endtask
    task automatic t_ref();
        frm(DACURC_CMD_REF, 4'hF, 16'hFFFF);
        chk({11'h0, ref_off}, 12'h001);
        frm(DACURC_CMD_REF, 4'hA, 16'h5556);
        chk({11'h0, ref_off}, 12'h000);
        frm(DACURC_CMD_REF, 4'h0, 16'h0001);
        chk({11'h0, ref_off}, 12'h001);
        $display("test reference done");
    endtask
    task automatic t_hw();
        sel = 0;
        clks(6);
        hw_n = 0;
        clks(8);
        frm(DACURC_CMD_WR_UPD, 4'h9, 16'h3210);
        chk(code_a, DACURC_ZERO_CODE);
        chk(code_b, DACURC_ZERO_CODE);
        hw_n = 1;
        clks(8);
        chk(code_b, DACURC_ZERO_CODE);
        frm(DACURC_CMD_UPD, 4'h1, 16'h0000);
        chk(code_a, DACURC_ZERO_CODE);
        $display("test hardware reset done");
    endtask
    task automatic t_sw();
        sel = 1;
        clks(6);
        frm(DACURC_CMD_SWRST, 4'h0, 16'h0000);
        chk({11'h0, busy}, 12'h001);
        wait_por();
        chk(code_a, DACURC_MID_CODE);
        chk(code_b, DACURC_MID_CODE);
        chk({11'h0, ref_off}, 12'h000);
        chk({10'h0, mask}, 12'h000);
        $display("test software reset done");
    endtask
    initial begin
        clks(2);
        rst = 0;
        t_por();
        t_cmds();
        t_mask();
        t_ref();
        t_hw();
        t_sw();
        stop_test();
    end
    initial begin
        #200000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule
